// ### rtl/fbep_pkg.sv
// Package of constants for the flash block erase and protection logic
package fbep_pkg;
	// ****************************************************************
	// Geometry
	// ****************************************************************
	localparam int FLASH_BYTES   = 65536;
	localparam int BLOCK_BYTES   = 1024;
	localparam int PROT_BYTES    = 2048;
	localparam int WORD_BYTES    = 4;
	localparam int DATA_W        = 32;
	localparam int ADDR_W        = $clog2(FLASH_BYTES);
	localparam int WORD_AW       = ADDR_W - $clog2(WORD_BYTES);
	localparam int NUM_WORDS     = FLASH_BYTES / WORD_BYTES;
	localparam int NUM_BLOCKS    = FLASH_BYTES / BLOCK_BYTES;
	localparam int NUM_PROT      = FLASH_BYTES / PROT_BYTES;
	localparam int BLK_LSB       = $clog2(BLOCK_BYTES);
	localparam int PROT_LSB      = $clog2(PROT_BYTES);
	localparam int BLK_W         = ADDR_W - BLK_LSB;
	localparam int PROT_W        = ADDR_W - PROT_LSB;
	localparam int WPB           = BLOCK_BYTES / WORD_BYTES;
	localparam int WPB_W         = $clog2(WPB);
	// ****************************************************************
	// Values
	// ****************************************************************
	localparam logic [DATA_W-1:0] ERASED_WORD  = 32'hffffffff;
	localparam logic [DATA_W-1:0] BLOCKED_WORD = 32'h00000000;
	localparam logic [WPB_W-1:0]  WPB_LAST     = 8'hff;
	// ****************************************************************
	// Protection modes and requesters
	// ****************************************************************
	typedef enum logic [1:0] {
		FBEP_OPEN = 2'b00,
		FBEP_RO   = 2'b01,
		FBEP_XO   = 2'b10
	} fbep_prot_e;
	typedef enum logic [1:0] {
		FBEP_SRC_FETCH = 2'b00,
		FBEP_SRC_DATA  = 2'b01,
		FBEP_SRC_DEBUG = 2'b10
	} fbep_src_e;
endpackage : fbep_pkg

// ### rtl/fbep_core.sv
// Flash array with per-block erase and per-pair protection
`timescale 1ns/10ps
// Functional notes
// - Flash holds 64 KB, addressed by this access logic.
// - Each 1 KB block erases alone without touching others.
// - An erased block reads back as all ones.
// - Protection applies per 2 KB pair of blocks, each set independently.
// - Each pair can be read-only or execute-only.
// - Read-only pairs refuse erase and program but allow reads.
// - Execute-only pairs refuse writes and serve instruction fetches only.
// - Execute-only contents hidden from data reads and debugger reads.
module fbep_core (
	input  wire logic                           mclk_i,
	input  wire logic                           arst_n_i,
	input  wire logic                           rd_req_i,
	input  wire fbep_pkg::fbep_src_e            rd_src_i,
	input  wire logic [fbep_pkg::ADDR_W-1:0]    rd_addr_i,
	output logic                                rd_ack_o,
	output logic [fbep_pkg::DATA_W-1:0]         rd_data_o,
	output logic                                rd_blocked_o,
	input  wire logic                           pgm_req_i,
	input  wire logic [fbep_pkg::ADDR_W-1:0]    pgm_addr_i,
	input  wire logic [fbep_pkg::DATA_W-1:0]    pgm_data_i,
	input  wire logic                           ers_req_i,
	input  wire logic [fbep_pkg::ADDR_W-1:0]    ers_addr_i,
	output logic                                busy_o,
	output logic                                done_o,
	output logic                                refused_o,
	input  wire logic                           prot_we_i,
	input  wire logic [fbep_pkg::PROT_W-1:0]    prot_idx_i,
	input  wire fbep_pkg::fbep_prot_e           prot_mode_i
);
	import fbep_pkg::*;

	// ****************************************************************
	// Storage and protection state
	// ****************************************************************
	logic [DATA_W-1:0] mem [NUM_WORDS];
	fbep_prot_e        prot_ff [NUM_PROT];

	typedef enum logic [1:0] {
		FBEP_IDLE  = 2'b00,
		FBEP_ERASE = 2'b01
	} fbep_state_e;
	fbep_state_e       state_ff;
	logic [BLK_W-1:0]  ers_blk_ff;
	logic [WPB_W-1:0]  ers_cnt_ff;

	// ****************************************************************
	// Decode
	// ****************************************************************
	wire logic [PROT_W-1:0] rd_unit  = rd_addr_i[ADDR_W-1:PROT_LSB];
	wire logic [PROT_W-1:0] pgm_unit = pgm_addr_i[ADDR_W-1:PROT_LSB];
	wire logic [PROT_W-1:0] ers_unit = ers_addr_i[ADDR_W-1:PROT_LSB];
	wire fbep_prot_e rd_mode  = prot_ff[rd_unit];
	wire fbep_prot_e pgm_mode = prot_ff[pgm_unit];
	wire fbep_prot_e ers_mode = prot_ff[ers_unit];
	wire logic rd_hide  = (rd_mode == FBEP_XO)
		&& (rd_src_i != FBEP_SRC_FETCH);
	wire logic pgm_lock = (pgm_mode != FBEP_OPEN);
	wire logic ers_lock = (ers_mode != FBEP_OPEN);
	wire logic idle     = (state_ff == FBEP_IDLE);
	wire logic ers_go   = idle && ers_req_i && !ers_lock;
	// Erase wins over a program that arrives in the same cycle
	wire logic pgm_go   = idle && !ers_req_i && pgm_req_i && !pgm_lock;
	wire logic refuse   = idle && ((ers_req_i && ers_lock)
		|| (!ers_req_i && pgm_req_i && pgm_lock));
	wire logic ers_last = (state_ff == FBEP_ERASE)
		&& (ers_cnt_ff == WPB_LAST);
	wire logic [WORD_AW-1:0] ers_word = {ers_blk_ff, ers_cnt_ff};
	wire logic [WORD_AW-1:0] pgm_word = pgm_addr_i[ADDR_W-1:ADDR_W-WORD_AW];
	wire logic [WORD_AW-1:0] rd_word  = rd_addr_i[ADDR_W-1:ADDR_W-WORD_AW];

	// ****************************************************************
	// Protection settings
	// ****************************************************************
	generate
		for (genvar u = 0; u < NUM_PROT; u++) begin : g_prot
			always_ff @(posedge mclk_i or negedge arst_n_i) begin
				if (!arst_n_i) begin
					prot_ff[u] <= FBEP_OPEN;
				end else if (prot_we_i && prot_idx_i == PROT_W'(u)) begin
					prot_ff[u] <= prot_mode_i;
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Erase sequencer
	// ****************************************************************
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_ff   <= FBEP_IDLE;
			ers_blk_ff <= '0;
			ers_cnt_ff <= '0;
		end else begin
			unique case (state_ff)
				FBEP_IDLE: begin
					ers_cnt_ff <= '0;
					if (ers_go) begin
						state_ff   <= FBEP_ERASE;
						ers_blk_ff <= ers_addr_i[ADDR_W-1:BLK_LSB];
					end
				end
				FBEP_ERASE: begin
					ers_cnt_ff <= ers_cnt_ff + 1'b1;
					if (ers_last) begin
						state_ff <= FBEP_IDLE;
					end
				end
				default: state_ff <= FBEP_IDLE;
			endcase
		end
	end

	// Array writes: erase fills ones, program clears bits only
	// The array has no reset; a block must be erased before it is read
	always_ff @(posedge mclk_i) begin
		if (state_ff == FBEP_ERASE) begin
			mem[ers_word] <= ERASED_WORD;
		end else if (pgm_go) begin
			mem[pgm_word] <= mem[pgm_word] & pgm_data_i;
		end
	end

	// ****************************************************************
	// Status
	// ****************************************************************
	wire logic nxt_busy = ers_go || (state_ff == FBEP_ERASE && !ers_last);
	wire logic nxt_done = ers_last || pgm_go;

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			busy_o    <= 1'b0;
			done_o    <= 1'b0;
			refused_o <= 1'b0;
		end else begin
			busy_o    <= nxt_busy;
			done_o    <= nxt_done;
			refused_o <= refuse;
		end
	end

	// ****************************************************************
	// Read port
	// ****************************************************************
	// Hidden reads answer in the next cycle like any read, with a fixed word, never the array
	wire logic [DATA_W-1:0] nxt_rd_data = rd_hide ? BLOCKED_WORD
		: mem[rd_word];

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_ack_o     <= 1'b0;
			rd_blocked_o <= 1'b0;
			rd_data_o    <= '0;
		end else begin
			rd_ack_o     <= rd_req_i;
			rd_blocked_o <= rd_req_i && rd_hide;
			if (rd_req_i) begin
				rd_data_o <= nxt_rd_data;
			end
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_read_no_stall: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		rd_req_i |=> rd_ack_o)
		else $error("read not answered next cycle");
	a_ack_pulse: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		!rd_req_i |=> !rd_ack_o)
		else $error("read answered without a request");
	a_hide_fixed: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		rd_blocked_o |-> rd_ack_o && rd_data_o == BLOCKED_WORD)
		else $error("blocked read did not return the fixed word");
	a_xo_hides_data: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		rd_req_i && rd_mode == FBEP_XO && rd_src_i != FBEP_SRC_FETCH
		|=> rd_blocked_o && rd_data_o == BLOCKED_WORD)
		else $error("execute-only data leaked");
	a_fetch_served: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		rd_req_i && rd_src_i == FBEP_SRC_FETCH |=> !rd_blocked_o)
		else $error("instruction fetch blocked");
	a_ro_reads_ok: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		rd_req_i && rd_mode != FBEP_XO |=> !rd_blocked_o)
		else $error("read-only read blocked");
	a_locked_refused: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		idle && ers_req_i && ers_mode != FBEP_OPEN
		|=> refused_o && !busy_o)
		else $error("erase of protected unit not refused");
	a_pgm_refused: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		idle && !ers_req_i && pgm_req_i && pgm_mode != FBEP_OPEN
		|=> refused_o && !done_o)
		else $error("program of protected unit not refused");
	a_locked_kept: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		idle && !ers_req_i && pgm_req_i && pgm_lock
		|=> mem[$past(pgm_word)] == $past(mem[pgm_word]))
		else $error("refused program changed the array");
	a_pgm_accepted: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		idle && !ers_req_i && pgm_req_i && pgm_mode == FBEP_OPEN
		|=> done_o && !refused_o)
		else $error("program of open unit not accepted");
	a_refuse_idle: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		!idle |=> !refused_o)
		else $error("refusal raised during an erase");
	a_erase_length: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		ers_go |=> (state_ff == FBEP_ERASE) [*8] ##249 done_o)
		else $error("erase length wrong");
	a_busy_in_erase: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		busy_o |-> state_ff == FBEP_ERASE)
		else $error("busy shown outside an erase");
	a_busy_ignores: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		!idle && pgm_req_i && !ers_last |=> !done_o)
		else $error("program accepted during an erase");
	a_erase_in_block: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		state_ff == FBEP_ERASE |=> $stable(ers_blk_ff))
		else $error("erase left its block");
	a_erase_ones: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		state_ff == FBEP_ERASE |=> mem[$past(ers_word)] == ERASED_WORD)
		else $error("erased word not all ones");
	a_prot_update: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		prot_we_i |=> prot_ff[$past(prot_idx_i)] == $past(prot_mode_i))
		else $error("protection setting not stored");
endmodule : fbep_core

// ### testbench/fbep_requester.sv
// Read requester model for fetch, data and debug paths
`timescale 1ns/10ps
module fbep_requester (
	input  wire logic                        mclk_i,
	input  wire logic                        go_i,
	input  wire fbep_pkg::fbep_src_e         src_i,
	input  wire logic [fbep_pkg::ADDR_W-1:0] addr_i,
	output logic                             req_o,
	output fbep_pkg::fbep_src_e              src_o,
	output logic [fbep_pkg::ADDR_W-1:0]      addr_o
);
	import fbep_pkg::*;
	// Idle address lines toggle so a stale address is never reused
	initial begin
		req_o = 1'h0;
		src_o = FBEP_SRC_FETCH;
		addr_o = '0;
		forever begin
			@(posedge mclk_i);
			req_o <= #1 go_i;
			src_o <= #1 go_i ? src_i : src_o;
			addr_o <= #1 go_i ? addr_i : ~addr_o;
		end
	end
endmodule : fbep_requester

// ### testbench/flash_block_erase_protection_tb.sv
// Testbench for the flash erase and protection logic
`timescale 1ns/10ps
module flash_block_erase_protection_tb;
	import fbep_pkg::*;
	typedef struct {
		fbep_prot_e m;
		fbep_src_e  s;
		logic [31:0] d;
		logic b;
	} fbep_row_s;
	localparam logic [31:0] PAT = 32'ha5a5a5a5;
	fbep_row_s rows [6] = '{'{FBEP_RO, FBEP_SRC_FETCH, PAT, 1'h0},
		'{FBEP_RO, FBEP_SRC_DATA, PAT, 1'h0},
		'{FBEP_RO, FBEP_SRC_DEBUG, PAT, 1'h0},
		'{FBEP_XO, FBEP_SRC_FETCH, PAT, 1'h0},
		'{FBEP_XO, FBEP_SRC_DATA, BLOCKED_WORD, 1'h1},
		'{FBEP_XO, FBEP_SRC_DEBUG, BLOCKED_WORD, 1'h1}};
	logic mclk_i = 1'h0, arst_n_i = 1'h0, go = 1'h0, pwe = 1'h0;
	logic pgm = 1'h0, ers = 1'h0, rreq, ack, blk, busy, done, refd;
	fbep_src_e gsrc = FBEP_SRC_FETCH, rsrc;
	fbep_prot_e pmode = FBEP_OPEN;
	logic [ADDR_W-1:0] gaddr = '0, waddr = '0, raddr;
	logic [PROT_W-1:0] pidx = '0;
	logic [31:0] wdata = '0, rdata;
	int bad_count = 0, checks = 0, n;
	fbep_requester fbep_requester_inst (.mclk_i(mclk_i), .go_i(go),
		.src_i(gsrc), .addr_i(gaddr), .req_o(rreq), .src_o(rsrc),
		.addr_o(raddr));
	fbep_core fbep_core_inst (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
		.rd_req_i(rreq), .rd_src_i(rsrc), .rd_addr_i(raddr), .rd_ack_o(ack),
		.rd_data_o(rdata), .rd_blocked_o(blk), .pgm_req_i(pgm),
		.pgm_addr_i(waddr), .pgm_data_i(wdata), .ers_req_i(ers),
		.ers_addr_i(waddr), .busy_o(busy), .done_o(done), .refused_o(refd),
		.prot_we_i(pwe), .prot_idx_i(pidx), .prot_mode_i(pmode));
	initial forever #5 mclk_i = ~mclk_i;
	task automatic tick;
		@(posedge mclk_i);
		#1;
	endtask : tick
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic hang(input logic ok);
		if (!ok) begin
			bad_count++;
			$display("Error at %0t: no answer", $time);
			give_verdict();
		end
	endtask : hang
	task automatic set_prot(input logic [PROT_W-1:0] u, input fbep_prot_e m);
		pidx = u;
		pmode = m;
		pwe = 1'h1;
		tick();
		pwe = 1'h0;
	endtask : set_prot
	task automatic rd(input fbep_src_e s, input logic [15:0] a,
		input logic [31:0] d, input logic b);
		gsrc = s;
		gaddr = a;
		go = 1'h1;
		tick();
		go = 1'h0;
		for (n = 0; n < 4 && ack !== 1'h1; n++) tick();
		hang(ack === 1'h1);
		check(rdata, d);
		check(32'(blk), 32'(b));
	endtask : rd
	task automatic op(input logic e, input logic [15:0] a,
		input logic [31:0] d, input logic r);
		waddr = a;
		wdata = d;
		ers = e;
		pgm = !e;
		tick();
		ers = 1'h0;
		pgm = 1'h0;
		if (e && !r) check(32'(busy), 32'h1);
		for (n = 0; n < 300 && done !== 1'h1 && refd !== 1'h1; n++) tick();
		hang(done === 1'h1 || refd === 1'h1);
		check(32'(refd), 32'(r));
		check(32'(done), 32'(!r));
		if (e && !r) check(32'(busy), 32'h0);
	endtask : op
	initial begin
		repeat (20) @(posedge mclk_i);
		#1 arst_n_i = 1'h1;
		check(32'({ack, blk, busy, done, refd}), 32'h0);
		$display("test reset done");
		op(1'h1, 16'h0000, 32'h0, 1'h0);
		op(1'h1, 16'h0400, 32'h0, 1'h0);
		op(1'h1, 16'hfc00, 32'h0, 1'h0);
		rd(FBEP_SRC_DATA, 16'hfffc, ERASED_WORD, 1'h0);
		op(1'h0, 16'h0400, 32'h12345678, 1'h0);
		op(1'h1, 16'h0000, 32'h0, 1'h0);
		rd(FBEP_SRC_DATA, 16'h0400, 32'h12345678, 1'h0);
		rd(FBEP_SRC_DEBUG, 16'h03fc, ERASED_WORD, 1'h0);
		op(1'h0, 16'h0000, PAT, 1'h0);
		$display("test erase done");
		foreach (rows[i]) begin
			pmode = rows[i].m;
			pwe = 1'h1;
			tick();
			pwe = 1'h0;
			rd(rows[i].s, 16'h0000, rows[i].d, rows[i].b);
			op(1'h1, 16'h0000, 32'h0, 1'h1);
		end
		op(1'h0, 16'h0004, 32'h0, 1'h1);
		op(1'h1, 16'h0400, 32'h0, 1'h1);
		op(1'h0, 16'h0800, 32'h0, 1'h0);
		set_prot(5'h00, FBEP_RO);
		op(1'h0, 16'h0000, 32'h0, 1'h1);
		rd(FBEP_SRC_DATA, 16'h0000, PAT, 1'h0);
		set_prot(5'h01, FBEP_RO);
		op(1'h1, 16'h0c00, 32'h0, 1'h1);
		op(1'h1, 16'h1000, 32'h0, 1'h0);
		$display("test protection done");
		arst_n_i = 1'h0;
		tick();
		check(32'({ack, blk, busy, done, refd}), 32'h0);
		check(rdata, 32'h0);
		arst_n_i = 1'h1;
		op(1'h0, 16'h0000, 32'h0, 1'h0);
		rd(FBEP_SRC_DEBUG, 16'h0000, 32'h0, 1'h0);
		$display("test reset again done");
		give_verdict();
	end
endmodule : flash_block_erase_protection_tb
